// [bench/arqcf_seq_model.sv]
// sequencer stand-in: one conversion result per go pulse
`timescale 1ns/1ns
module arqcf_seq_model
  import arqcf_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [3:0] i_tag,
  input wire logic [SAMPLE_W-1:0] i_sample,
  output logic o_done,
  output logic [2:0] o_chan,
  output logic o_batt,
  output logic [SAMPLE_W-1:0] o_sample
);
  initial begin
    o_done = 1'b0;
    o_chan = 3'h0;
    o_batt = 1'b0;
    o_sample = 12'h000;
  end
  // between results the buses toggle, so stale values never look valid
  always @(posedge i_clk) begin
    o_done <= i_go;
    if (i_go) begin
      o_chan <= i_tag[2:0];
      o_batt <= i_tag[3];
      o_sample <= i_sample;
    end else begin
      o_chan <= ~o_chan;
      o_batt <= ~o_batt;
      o_sample <= ~o_sample;
    end
  end
endmodule

// [bench/testbench.sv]
// self-checking bench of the result queue and hit flag block
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
  error_cnt++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module testbench
  import arqcf_pkg::*;
;
  logic I_REF_CLK = 1'b0;
  logic I_RESET = 1'b1;
  logic I_WR = 1'b0;
  logic I_RD = 1'b0;
  logic [ADDR_W-1:0] I_ADDR = 8'h00;
  logic [DATA_W-1:0] I_WDATA = 16'h0000;
  logic [HIT_W-1:0] I_CMP_HIT = 10'h000;
  logic [DATA_W-1:0] O_RDATA;
  logic O_PRESCALE_TICK, O_IRQ;
  logic [1:0] go = 2'h0;
  logic [3:0] tag = 4'h0;
  logic [SAMPLE_W-1:0] smp = 12'h000;
  logic d1, d2, b1, b2;
  logic [2:0] c1, c2;
  logic [SAMPLE_W-1:0] s1, s2;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;

  arqcf_seq_model seq1 (.i_clk(I_REF_CLK), .i_go(go[0]), .i_tag(tag),
    .i_sample(smp), .o_done(d1), .o_chan(c1), .o_batt(b1), .o_sample(s1));
  arqcf_seq_model seq2 (.i_clk(I_REF_CLK), .i_go(go[1]), .i_tag(tag),
    .i_sample(smp), .o_done(d2), .o_chan(c2), .o_batt(b2), .o_sample(s2));
  arqcf_top dut (.I_REF_CLK(I_REF_CLK), .I_RESET(I_RESET),
    .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
    .I_CMP_HIT(I_CMP_HIT), .I_SEQ1_DONE(d1), .I_SEQ1_CHAN(c1),
    .I_SEQ1_BATT(b1), .I_SEQ1_SAMPLE(s1), .I_SEQ2_DONE(d2),
    .I_SEQ2_CHAN(c2), .I_SEQ2_BATT(b2), .I_SEQ2_SAMPLE(s2),
    .O_RDATA(O_RDATA), .O_PRESCALE_TICK(O_PRESCALE_TICK), .O_IRQ(O_IRQ));

  // 25 MHz clock and a hang guard well above the expected run
  always #20 I_REF_CLK = ~I_REF_CLK;
  always @(posedge I_REF_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge I_REF_CLK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_REF_CLK);
    I_WR <= 1'b0;
  endtask

  // read; h pulses comparator hits in the read cycle itself
  task automatic rd(input logic [7:0] a, input logic [9:0] h,
      input logic [15:0] ex, input string nm);
    @(posedge I_REF_CLK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    I_CMP_HIT <= h;
    @(posedge I_REF_CLK);
    I_RD <= 1'b0;
    I_CMP_HIT <= 10'h000;
    @(negedge I_REF_CLK);
    `CHK(nm, ex, O_RDATA)
  endtask

  // irq is registered one cycle behind its cause
  task automatic irq_is(input logic ex, input string nm);
    repeat (2) @(posedge I_REF_CLK);
    @(negedge I_REF_CLK);
    `CHK(nm, ex, O_IRQ)
  endtask

  function automatic logic [3:0] tg(input int i);
    return (i == 7) ? TAG_BATT : 4'(i % 8);
  endfunction

  // queue word expected for entry i
  function automatic logic [15:0] qw(input int i);
    return {tg(i), 12'hFFF ^ 12'(i)};
  endfunction

  // even entries from sequencer one, odd from sequencer two
  task automatic push(input int i);
    @(posedge I_REF_CLK);
    go[i%2] <= 1'b1;
    tag <= tg(i);
    smp <= 12'hFFF ^ 12'(i);
    @(posedge I_REF_CLK);
    go <= 2'h0;
    repeat (2) @(posedge I_REF_CLK);
    @(negedge I_REF_CLK);
  endtask

  task automatic t_reset();
    rd(OFF_HIT_FLAGS, 10'h000, 16'h0000, "hit rst");
    rd(OFF_DIV, 10'h000, 16'h0000, "div rst");
    rd(OFF_QUEUE_POP, 10'h000, 16'h0000, "pop rst");
    rd(OFF_QUEUE_THR, 10'h000, 16'h0000, "thr rst");
    rd(OFF_MAIN_CTRL, 10'h000, CTRL_RST, "ctrl rst");
  endtask

  // unmapped reads double as the hit pulse
  task automatic t_hits();
    for (int i = 0; i < HIT_W; i++) begin
      rd(8'h30, 10'(1 << i), 16'h0000, "unmapped");
      rd(OFF_HIT_FLAGS, 10'h000, 16'(1 << i), "hit");
      rd(OFF_HIT_FLAGS, 10'h000, 16'h0000, "clr");
    end
    wr(OFF_HIT_FLAGS, 16'hFFFF);
    rd(OFF_HIT_FLAGS, 10'h004, 16'h0000, "hit wr");
    rd(OFF_HIT_FLAGS, 10'h000, 16'h0004, "kept");
    rd(OFF_IRQ_STAT, 10'h000, 16'h0003, "cmp stat");
    irq_is(1'b0, "irq off");
    wr(OFF_MAIN_CTRL, CTRL_RST | 16'h1000);
    irq_is(1'b1, "irq cmp");
    wr(OFF_IRQ_STAT, 16'h0001);
    irq_is(1'b0, "irq clr");
  endtask

  // overfill by one, then drain past empty
  task automatic t_queue();
    wr(OFF_QUEUE_THR, 16'h0002);
    wr(OFF_MAIN_CTRL, CTRL_RST | 16'h8000);
    for (int i = 0; i <= QUEUE_DEPTH; i++) begin
      push(i);
      if (i < 2) `CHK("irq lvl", logic'(i == 1), O_IRQ)
    end
    rd(OFF_QUEUE_STAT, 10'h000, 16'h0018, "full");
    wr(OFF_MAIN_CTRL, CTRL_RST);
    irq_is(1'b0, "irq qmask");
    // mixed entries are told apart by their channel tag only
    for (int i = 0; i < QUEUE_DEPTH; i++) begin
      rd(OFF_QUEUE_POP, 10'h000, qw(i), "pop");
    end
    rd(OFF_QUEUE_POP, 10'h000, 16'h0000, "pop empty");
    rd(OFF_QUEUE_STAT, 10'h000, 16'h0020, "empty");
    // battery sample alone in an empty queue
    push(7);
    rd(OFF_QUEUE_POP, 10'h000, qw(7), "pop batt");
  endtask

  // skip the one irregular gap, then count twelve periods
  task automatic t_div(input logic [7:0] d);
    int n;
    n = 0;
    wr(OFF_DIV, {8'hFF, d});
    rd(OFF_DIV, 10'h000, {8'h00, d}, "div");
    repeat (260) @(posedge I_REF_CLK);
    repeat (12 * (d + 1)) begin
      @(negedge I_REF_CLK);
      n += int'(O_PRESCALE_TICK === 1'b1);
    end
    `CHK("ticks", 12, n)
  endtask

  initial begin
    repeat (5) @(posedge I_REF_CLK);
    I_RESET <= 1'b0;
    t_reset();
    t_hits();
    t_queue();
    t_div(8'h03);
    t_div(8'(PRESCALE_TYP_SETTING));
    t_div(8'h00);
    end_sim();
  end
endmodule

// [src/arqcf_pkg.sv]
// shared constants of the converter result queue and compare flag block
package arqcf_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  // register offsets on the plain register port
  localparam logic [7:0] OFF_MAIN_CTRL = 8'h18;
  localparam logic [7:0] OFF_HIT_FLAGS = 8'h1A;
  localparam logic [7:0] OFF_DIV = 8'h1C;
  localparam logic [7:0] OFF_QUEUE_POP = 8'h20;
  localparam logic [7:0] OFF_QUEUE_THR = 8'h22;
  localparam logic [7:0] OFF_QUEUE_STAT = 8'h24;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h40;
  // comparator hit flags
  localparam int HIT_W = 10;
  localparam int CH_CMP_W = 8;
  localparam int BAT_UNDER_BIT = 8;
  localparam int BAT_OVER_BIT = 9;
  localparam logic [9:0] HIT_RST = 10'h000;
  // main control register
  localparam logic [15:0] CTRL_RST = 16'h0030;
  localparam logic [15:0] CTRL_WMASK = 16'hF03F;
  localparam int CTRL_QMASK_BIT = 15;
  localparam int CTRL_CMASK_BIT = 12;
  // divider and queue threshold fields
  localparam int DIV_W = 8;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam int THR_W = 4;
  localparam logic [3:0] THR_RST = 4'h0;
  // queue word layout
  localparam int SAMPLE_W = 12;
  localparam int TAG_W = 4;
  localparam int TAG_LSB = 12;
  localparam logic [3:0] TAG_BATT = 4'h8;
  localparam int QUEUE_DEPTH = 8;
  localparam int QCNT_W = 4;
  localparam int QSTAT_FULL_BIT = 4;
  localparam int QSTAT_EMPTY_BIT = 5;
  // interrupt status bits
  localparam int IRQ_CMP_BIT = 0;
  localparam int IRQ_QUEUE_BIT = 1;
  // rates, for choosing the divider setting
  localparam int REF_CLK_HZ = 25_000_000;
  localparam int PRESCALE_TYP_HZ = 1_000_000;
  localparam int PRESCALE_TYP_SETTING = REF_CLK_HZ / PRESCALE_TYP_HZ - 1;
endpackage

// [src/arqcf_queue.sv]
// result queue: flip-flop storage, two push ports, one pop port
`timescale 1ns/1ns
module arqcf_queue #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int CNT_W = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic i_push_a,
  input wire logic [WIDTH-1:0] i_data_a,
  input wire logic i_push_b,
  input wire logic [WIDTH-1:0] i_data_b,
  input wire logic i_pop,
  output logic [WIDTH-1:0] o_head,
  output logic [CNT_W-1:0] o_count,
  output logic o_full,
  output logic o_empty
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [CNT_W-1:0] count_ff;

  // space is judged before this cycle's pop, so a full queue drops pushes
  wire logic take_a = i_push_a && (count_ff < DEPTH_C);
  wire logic take_b = i_push_b && ((count_ff + CNT_W'(take_a)) < DEPTH_C);
  wire logic do_pop = i_pop && (count_ff != '0);
  wire logic [AW-1:0] b_ptr = take_a ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
  wire logic [1:0] n_push = {1'b0, take_a} + {1'b0, take_b};

  assign o_head = mem_ff[rd_ptr_ff];
  assign o_count = count_ff;
  assign o_full = (count_ff == DEPTH_C);
  assign o_empty = (count_ff == '0);

  // pointers and fill count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      wr_ptr_ff <= AW'(wr_ptr_ff + n_push);
      rd_ptr_ff <= AW'(rd_ptr_ff + (do_pop ? 1'b1 : 1'b0));
      count_ff <= CNT_W'(count_ff + n_push - (do_pop ? 1 : 0));
    end
  end

  // storage has no reset; empty entries are never shown
  always_ff @(posedge clk) begin
    if (take_a) begin
      mem_ff[wr_ptr_ff] <= i_data_a;
    end
    if (take_b) begin
      mem_ff[b_ptr] <= i_data_b;
    end
  end
endmodule

// [src/arqcf_top.sv]
// converter result queue, comparator hit flags and prescale divider
//
// Chosen here: strobed register access.
`timescale 1ns/1ns
// Notes on behaviour
// [RQ1] a comparator's valid compare sets its hit flag
// [RQ2] any hit also sets the summary compare status bit
// [RQ3] reading hit flags returns them and clears them; writes ignored
// [RQ4] battery over hit is bit 9; bits 15-10 read zero
// [RQ5] battery under hit is bit 8; all flags reset to zero
// [RQ6] channel comparators 0-7 map to flag bits 0-7
// [RQ7] prescale rate is clock divided by divider field plus one
// [RQ8] prescale tick is the time base for timers and sequencers
// [RQ9] software picks the divider to give about 1 MHz
// [RQ10] only completed sequencer conversions push the queue
// [RQ11] reader identifies mixed sequencer samples by channel tag only
// [RQ12] each queue read returns next entry and advances the pointer
// [RQ13] channel tag sits in bits 15-12 of the queue word
// [RQ14] sample is unsigned 12 bits, all ones is full scale
// [RQ15] tags 0-7 name inputs, tag 8 names the battery reference
// [RQ16] the queue holds eight entries
// [RQ17] fill reaching threshold sets queue status and may interrupt
// [RQ18] software sets threshold only to values one through eight
// [RQ19] queue status interrupts only while control bit 15 is one
// [RQ20] compare status interrupts only while control bit 12 is one
// [RQ21] pushes into a full queue are discarded
// [RQ22] a hit in the clearing read cycle stays set
// [RQ23] reading an empty queue leaves the read pointer alone
module arqcf_top
  import arqcf_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  input wire logic [ADDR_W-1:0] I_ADDR,
  input wire logic [DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [HIT_W-1:0] I_CMP_HIT,
  input wire logic I_SEQ1_DONE,
  input wire logic [2:0] I_SEQ1_CHAN,
  input wire logic I_SEQ1_BATT,
  input wire logic [SAMPLE_W-1:0] I_SEQ1_SAMPLE,
  input wire logic I_SEQ2_DONE,
  input wire logic [2:0] I_SEQ2_CHAN,
  input wire logic I_SEQ2_BATT,
  input wire logic [SAMPLE_W-1:0] I_SEQ2_SAMPLE,
  output logic [DATA_W-1:0] O_RDATA,
  output logic O_PRESCALE_TICK,
  output logic O_IRQ
);
  logic [DATA_W-1:0] ctrl_ff;
  logic [HIT_W-1:0] hit_ff;
  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] div_cnt_ff;
  logic [THR_W-1:0] thr_ff;
  logic cmp_stat_ff;
  logic tick_ff;
  logic irq_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] q_head;
  logic [QCNT_W-1:0] q_count;
  logic q_full;
  logic q_empty;

  // address decode of the strobes
  wire logic wr_ctrl = I_WR && (I_ADDR == OFF_MAIN_CTRL);
  wire logic wr_div = I_WR && (I_ADDR == OFF_DIV);
  wire logic wr_thr = I_WR && (I_ADDR == OFF_QUEUE_THR);
  wire logic wr_irq = I_WR && (I_ADDR == OFF_IRQ_STAT);
  wire logic rd_hit = I_RD && (I_ADDR == OFF_HIT_FLAGS);
  wire logic rd_queue = I_RD && (I_ADDR == OFF_QUEUE_POP);

  // hit flags: hardware set beats the read clear
  wire logic any_hit = |I_CMP_HIT; // [RQ2]
  wire logic [HIT_W-1:0] nxt_hit =
    (rd_hit ? HIT_RST : hit_ff) | I_CMP_HIT; // [RQ1] [RQ3] [RQ22]

  // queue words: tag above the 12-bit sample, battery gets its own code
  wire logic [TAG_W-1:0] tag1 =
    I_SEQ1_BATT ? TAG_BATT : {1'b0, I_SEQ1_CHAN}; // [RQ15]
  wire logic [TAG_W-1:0] tag2 =
    I_SEQ2_BATT ? TAG_BATT : {1'b0, I_SEQ2_CHAN}; // [RQ15]
  wire logic [DATA_W-1:0] word1 = {tag1, I_SEQ1_SAMPLE}; // [RQ13] [RQ14]
  wire logic [DATA_W-1:0] word2 = {tag2, I_SEQ2_SAMPLE}; // [RQ13] [RQ14]

  // level status: fill has reached the programmed threshold
  wire logic q_level_hit = (q_count >= QCNT_W'(thr_ff)); // [RQ17]
  wire logic div_match = (div_cnt_ff == div_ff);

  // read data selection; reserved bits and unmapped offsets read zero
  wire logic [DATA_W-1:0] rd_mux =
    (I_ADDR == OFF_MAIN_CTRL) ? (ctrl_ff & CTRL_WMASK) :
    (I_ADDR == OFF_HIT_FLAGS) ? {6'h00, hit_ff} : // [RQ4] [RQ5] [RQ6]
    (I_ADDR == OFF_DIV) ? {8'h00, div_ff} :
    (I_ADDR == OFF_QUEUE_POP) ? (q_empty ? 16'h0000 : q_head) : // [RQ12]
    (I_ADDR == OFF_QUEUE_THR) ? {12'h000, thr_ff} :
    (I_ADDR == OFF_QUEUE_STAT) ? {10'h000, q_empty, q_full, q_count} :
    (I_ADDR == OFF_IRQ_STAT) ? {14'h0000, q_level_hit, cmp_stat_ff} :
    16'h0000;

  // result queue; only sequencer completions push it
  arqcf_queue #(
    .WIDTH(DATA_W),
    .DEPTH(QUEUE_DEPTH),
    .CNT_W(QCNT_W)
  ) u_queue (
    .clk(I_REF_CLK),
    .rst(I_RESET),
    .i_push_a(I_SEQ1_DONE), // [RQ10] [RQ21]
    .i_data_a(word1),
    .i_push_b(I_SEQ2_DONE), // [RQ10] [RQ21]
    .i_data_b(word2),
    .i_pop(rd_queue), // [RQ12] [RQ23]
    .o_head(q_head),
    .o_count(q_count),
    .o_full(q_full),
    .o_empty(q_empty)
  );

  // software registers; the hit flag register takes no write
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      ctrl_ff <= CTRL_RST;
      div_ff <= DIV_RST;
      thr_ff <= THR_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= I_WDATA & CTRL_WMASK;
      end
      if (wr_div) begin
        div_ff <= I_WDATA[DIV_W-1:0]; // [RQ7]
      end
      if (wr_thr) begin
        thr_ff <= I_WDATA[THR_W-1:0];
      end
    end
  end

  // hit flags and sticky compare summary; write one clears, set wins
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      hit_ff <= HIT_RST; // [RQ5]
      cmp_stat_ff <= 1'b0;
    end else begin
      hit_ff <= nxt_hit;
      cmp_stat_ff <= any_hit ||
        (cmp_stat_ff && !(wr_irq && I_WDATA[IRQ_CMP_BIT])); // [RQ2]
    end
  end

  // prescale divider: one tick every setting plus one cycles
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      div_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      div_cnt_ff <= div_match ? '0 : DIV_W'(div_cnt_ff + 1'b1); // [RQ7]
      tick_ff <= div_match; // [RQ8]
    end
  end

  // masked interrupt and registered read data
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      irq_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      irq_ff <= (q_level_hit && ctrl_ff[CTRL_QMASK_BIT]) || // [RQ19]
        (cmp_stat_ff && ctrl_ff[CTRL_CMASK_BIT]); // [RQ20]
      rdata_ff <= I_RD ? rd_mux : '0;
    end
  end

  assign O_RDATA = rdata_ff;
  assign O_PRESCALE_TICK = tick_ff;
  assign O_IRQ = irq_ff;

  // helper: cycles since the last tick, and whether the divider moved
  logic [DIV_W:0] gap_ff;
  logic div_moved_ff;
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      gap_ff <= '0;
      div_moved_ff <= 1'b1;
    end else begin
      gap_ff <= tick_ff ? (DIV_W+1)'(1) : (DIV_W+1)'(gap_ff + 1'b1);
      div_moved_ff <= wr_div || (div_moved_ff && !tick_ff);
    end
  end

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RESET);

  // helper: no sequencer result in this cycle
  wire logic no_push = !I_SEQ1_DONE && !I_SEQ2_DONE;

  // helper: exactly one sequencer pushes into an empty queue, so the
  // new entry is the head in the next cycle whatever the pointers are
  wire logic one_push = (I_SEQ1_DONE != I_SEQ2_DONE) && q_empty;
  wire logic one_batt = I_SEQ1_DONE ? I_SEQ1_BATT : I_SEQ2_BATT;
  wire logic [2:0] one_chan = I_SEQ1_DONE ? I_SEQ1_CHAN : I_SEQ2_CHAN;
  wire logic [SAMPLE_W-1:0] one_sample =
    I_SEQ1_DONE ? I_SEQ1_SAMPLE : I_SEQ2_SAMPLE;

  // step one of a clearing read: no hit lands in the same cycle
  sequence s_hit_read;
    rd_hit && (I_CMP_HIT == '0);
  endsequence

  // step two: flags empty and the reserved bits of the answer low
  sequence s_flags_gone;
    (hit_ff == '0) && (O_RDATA[15:10] == 6'h00);
  endsequence

  // a lone push of an input channel, and of the battery reference
  sequence s_push_chan;
    one_push && !one_batt;
  endsequence

  sequence s_push_batt;
    one_push && one_batt;
  endsequence

  // hit flags: set by hits, kept until read, cleared only by a read
  a_hit_sets: assert property ((I_CMP_HIT != '0) |=> // [RQ1] [RQ6]
    ((hit_ff & $past(I_CMP_HIT)) == $past(I_CMP_HIT)))
    else $error("hit flag not set by comparator");

  a_hit_hold: assert property ((!rd_hit && (I_CMP_HIT == '0)) |=> // [RQ3]
    (hit_ff == $past(hit_ff)))
    else $error("hit flags changed without a hit or a read");

  a_read_clears: assert property (s_hit_read |=> s_flags_gone) // [RQ3]
    else $error("hit read did not clear flags");

  a_read_shows: assert property (rd_hit |=> // [RQ3] [RQ4]
    (O_RDATA == {6'h00, $past(hit_ff)}))
    else $error("hit read returned wrong value");

  a_hit_survives: assert property ((rd_hit && (I_CMP_HIT != '0)) |=> // [RQ22]
    (hit_ff == $past(I_CMP_HIT)))
    else $error("hit lost during clearing read");

  // compare summary: set by any hit, left alone by other traffic
  a_cmp_summary: assert property (any_hit |=> cmp_stat_ff) // [RQ2]
    else $error("compare status not set by hit");

  a_cmp_sticky: assert property ((cmp_stat_ff && !wr_irq) |=> // [RQ2]
    cmp_stat_ff)
    else $error("compare status dropped without a clear");

  // prescale divider: spacing once a write has settled, one-cycle pulses
  a_tick_gap: assert property ((tick_ff && !div_moved_ff) |-> // [RQ7]
    (gap_ff == (DIV_W+1)'(div_ff) + 1'b1))
    else $error("prescale tick spacing wrong");

  a_tick_div1: assert property (((div_ff == '0) && !div_moved_ff) |-> // [RQ8]
    tick_ff [*2])
    else $error("divide by one not ticking every cycle");

  a_tick_pulse: assert property ((tick_ff && (div_ff != '0)) |=> // [RQ7]
    !tick_ff)
    else $error("prescale tick longer than one cycle");

  // result queue: sources, order, depth and the word layout
  a_push_source: assert property ((q_count > $past(q_count)) |-> // [RQ10]
    $past(I_SEQ1_DONE || I_SEQ2_DONE))
    else $error("queue grew without a sequencer push");

  a_queue_idle: assert property ((!rd_queue && no_push) |=> // [RQ10] [RQ12]
    (q_count == $past(q_count)))
    else $error("queue count moved without push or read");

  a_pop_word: assert property ((rd_queue && !q_empty) |=> // [RQ12] [RQ13]
    (O_RDATA == $past(q_head)))
    else $error("queue read returned wrong word");

  a_pop_step: assert property ((rd_queue && !q_empty && no_push) |=> // [RQ12]
    (q_count == $past(q_count) - 1'b1))
    else $error("queue read did not advance");

  a_empty_read: assert property ((rd_queue && q_empty && no_push) |=> // [RQ23]
    q_empty && (O_RDATA == 16'h0000))
    else $error("empty queue read moved the queue");

  a_depth_cap: assert property (q_count <= QCNT_W'(QUEUE_DEPTH)) // [RQ16]
    else $error("queue count above depth");

  a_full_drop: assert property ((q_full && !rd_queue) |=> // [RQ21]
    q_full && (q_head == $past(q_head)))
    else $error("full queue overwritten");

  a_tag_chan: assert property (s_push_chan |=> // [RQ13] [RQ15]
    (q_head[DATA_W-1:TAG_LSB] == {1'b0, $past(one_chan)}))
    else $error("channel tag wrong in queue word");

  a_tag_batt: assert property (s_push_batt |=> // [RQ15]
    (q_head[DATA_W-1:TAG_LSB] == TAG_BATT))
    else $error("battery tag wrong in queue word");

  a_sample_kept: assert property (one_push |=> // [RQ14]
    (q_head[SAMPLE_W-1:0] == $past(one_sample)))
    else $error("sample bits wrong in queue word");

  // interrupt output: follows the enabled sources one cycle late
  a_irq_queue: assert property ((q_level_hit && // [RQ17] [RQ19]
    ctrl_ff[CTRL_QMASK_BIT]) |=> O_IRQ)
    else $error("queue level interrupt missing");

  a_irq_cmp: assert property ((cmp_stat_ff && // [RQ20]
    ctrl_ff[CTRL_CMASK_BIT]) |=> O_IRQ)
    else $error("compare interrupt missing");

  a_irq_masked: assert property ((!ctrl_ff[CTRL_QMASK_BIT] &&
    !ctrl_ff[CTRL_CMASK_BIT]) |=> !O_IRQ) // [RQ19] [RQ20]
    else $error("interrupt raised while masked");

  a_irq_quiet: assert property (!( // [RQ19] [RQ20]
    (q_level_hit && ctrl_ff[CTRL_QMASK_BIT]) ||
    (cmp_stat_ff && ctrl_ff[CTRL_CMASK_BIT])) |=> !O_IRQ)
    else $error("interrupt raised with no enabled source");
endmodule

// [src/arqcf_top_fix_note.sv]
// spare source file of the block: it holds no logic of its own
